//--- tb/psl_board.sv
// board model: strap resistors, internal pulls and floating pins
`timescale 1ns/10ps
module psl_board (
    input  wire logic        aclk,
    input  wire logic [11:0] strap_val,
    input  wire logic [11:0] strap_mask,
    input  wire logic        strap_pull_en,
    input  wire logic [11:0] strap_pull_up,
    input  wire logic [11:0] strap_pin_out,
    input  wire logic [11:0] strap_pin_oe_n,
    output logic      [11:0] pin_level
);
    logic tgl_r = 1'b0;
    always @(posedge aclk)
        tgl_r <= ~tgl_r;
    // a floating pin must not look like a held level
    always_comb
        for (int i = 0; i < 12; i++)
            if (!strap_pin_oe_n[i])
                pin_level[i] = strap_pin_out[i];
            else if (strap_mask[i])
                pin_level[i] = strap_val[i];
            else if (strap_pull_en)
                pin_level[i] = strap_pull_up[i];
            else
                pin_level[i] = tgl_r ^ i[0];
endmodule // psl_board

//--- tb/psl_strap_latch_chk.sv
// concurrent checks on the strap latch ports
`timescale 1ns/10ps
module psl_strap_latch_chk (
    input wire        aclk,
    input wire        aresetn,
    input wire [11:0] strap_pin_in,
    input wire [11:0] strap_pin_oe_n,
    input wire        strap_pull_en,
    input wire [4:0]  mgmt_frame_addr,
    input wire [4:0]  mgmt_addr,
    input wire        addr_match,
    input wire        addr_is_bcast,
    input wire [2:0]  mode_code,
    input wire        mode_rmii,
    input wire        mode_b2b,
    input wire        mode_reserved,
    input wire [15:0] ctrl_seed,
    input wire [15:0] adv_seed,
    input wire        nand_tree_en,
    input wire        straps_valid,
    input wire        s_axi_bvalid,
    input wire [1:0]  s_axi_bresp
);
    logic [11:0] d1_r, d2_r, d3_r;
    // pin levels as the synchroniser saw them at the capture edge
    always @(posedge aclk)
    begin
        d1_r <= strap_pin_in;
        d2_r <= d1_r;
        d3_r <= d2_r;
    end
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_upper_zero: assert property (mgmt_addr[4:3] == 2'b00)
        else $error("upper address bits not zero");
    a_capture_edge: assert property (aresetn && !$past(aresetn) |-> !straps_valid ##1 straps_valid)
        else $error("capture not on first edge after release");
    a_addr_mode_cap: assert property ($rose(straps_valid) |-> mgmt_addr[2:0] == d3_r[2:0] && mode_code == d3_r[5:3])
        else $error("address or mode not captured");
    a_ctrl_cap: assert property ($rose(straps_valid) |->
        ctrl_seed == {2'b00, d3_r[7], d3_r[9], 1'b0, d3_r[6], 1'b0, d3_r[8], 8'h00})
        else $error("control seed wrong");
    a_flags_cap: assert property ($rose(straps_valid) |-> addr_is_bcast == !d3_r[10] && nand_tree_en == !d3_r[11])
        else $error("broadcast or test flag wrong");
    a_mode_dec: assert property (mode_rmii == (mode_code == 3'h1) && mode_b2b == (mode_code == 3'h5)
        && mode_reserved == !(mode_rmii || mode_b2b))
        else $error("mode decode wrong");
    a_adv_speed: assert property (adv_seed == (ctrl_seed[13] ? 16'h01E1 : 16'h0061))
        else $error("advertisement speed wrong");
    a_straps_held: assert property (straps_valid && $past(straps_valid) |->
        $stable({mgmt_addr, mode_code, ctrl_seed, addr_is_bcast, nand_tree_en}))
        else $error("captured straps changed");
    a_addr_match: assert property ($past(straps_valid) && straps_valid |-> addr_match ==
        ($past(mgmt_frame_addr) == mgmt_addr || $past(mgmt_frame_addr) == 5'h0 && addr_is_bcast))
        else $error("address match wrong");
    a_pins_input: assert property (strap_pull_en == !straps_valid && (straps_valid || strap_pin_oe_n == 12'hFFF))
        else $error("strap pins driven before capture");
    c_capture: cover property ($rose(straps_valid));
    c_match: cover property (addr_match && mgmt_addr == 5'h0);
    c_b2b: cover property (straps_valid && mode_b2b);
    c_slverr: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule // psl_strap_latch_chk
bind psl_strap_latch psl_strap_latch_chk u_chk (.aclk(aclk), .aresetn(aresetn), .strap_pin_in(strap_pin_in),
    .strap_pin_oe_n(strap_pin_oe_n), .strap_pull_en(strap_pull_en), .mgmt_frame_addr(mgmt_frame_addr),
    .mgmt_addr(mgmt_addr), .addr_match(addr_match), .addr_is_bcast(addr_is_bcast), .mode_code(mode_code),
    .mode_rmii(mode_rmii), .mode_b2b(mode_b2b), .mode_reserved(mode_reserved), .ctrl_seed(ctrl_seed),
    .adv_seed(adv_seed), .nand_tree_en(nand_tree_en), .straps_valid(straps_valid),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bresp(s_axi_bresp));

//--- tb/tb.sv
// self-checking bench for the strap latch
`timescale 1ns/10ps
`include "psl_regs.vh"
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin failures++; \
    $display("ERROR t=%0t got %0h exp %0h", $time, (a), (e)); end end
module tb;
    logic        aclk = 0, aresetn = 0;
    logic [7:0]  awaddr = 0, araddr = 0;
    logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [31:0] wdata = 0, rdata;
    logic [1:0]  bresp, rresp;
    logic [11:0] pin, pout, oe_n, pull_up, fout = 0, fdrv = 0, bval = 0, bmask = 0;
    logic        pull_en, match, bcast, rmii, b2b, rsvd, nand_en, valid;
    logic [4:0]  frame = 0, maddr;
    logic [2:0]  mode;
    logic [15:0] ctrl, adv;
    int          failures = 0, total_checks = 0;
    logic [31:0] rd_v;
    logic [1:0]  rs;
    logic [11:0] last_s;
    always #25 aclk = ~aclk;
    psl_strap_latch dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .strap_pin_in(pin), .strap_pin_out(pout), .strap_pin_oe_n(oe_n),
        .strap_pull_en(pull_en), .strap_pull_up(pull_up), .func_pin_out(fout), .func_pin_drive(fdrv),
        .mgmt_frame_addr(frame), .mgmt_addr(maddr), .addr_match(match), .addr_is_bcast(bcast),
        .mode_code(mode), .mode_rmii(rmii), .mode_b2b(b2b), .mode_reserved(rsvd), .ctrl_seed(ctrl),
        .adv_seed(adv), .nand_tree_en(nand_en), .straps_valid(valid));
    psl_board u_board (.aclk(aclk), .strap_val(bval), .strap_mask(bmask), .strap_pull_en(pull_en),
        .strap_pull_up(pull_up), .strap_pin_out(pout), .strap_pin_oe_n(oe_n), .pin_level(pin));
    task automatic print_verdict;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // handshakes judged at the falling edge: inputs only move at rising edges
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        bit aw_h, w_h, done;
        @(posedge aclk);
        awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
        for (int n = 0; n < 50 && !done; n++)
        begin
            @(negedge aclk);
            aw_h = awvalid && awready; w_h = wvalid && wready; done = bvalid; r = bresp;
            @(posedge aclk);
            if (aw_h) awvalid <= 0;
            if (w_h) wvalid <= 0;
            if (done) bready <= 0;
        end
        if (!done)
        begin
            failures++;
            print_verdict();
        end
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        bit ar_h, done;
        @(posedge aclk);
        araddr <= a; arvalid <= 1; rready <= 1;
        for (int n = 0; n < 50 && !done; n++)
        begin
            @(negedge aclk);
            ar_h = arvalid && arready; done = rvalid; d = rdata; r = rresp;
            @(posedge aclk);
            if (ar_h) arvalid <= 0;
            if (done) rready <= 0;
        end
        if (!done)
        begin
            failures++;
            print_verdict();
        end
    endtask
    function automatic logic [31:0] exp_ctrl(logic [11:0] s);
        return {18'h0, s[7], s[9], 1'b0, s[6], 1'b0, s[8], 8'h00};
    endfunction
    function automatic logic [31:0] exp_stat(logic [11:0] s);
        return {19'h0, 2'b00, s[2:0], 2'b00, !s[11], !s[10], s[5:3] == 3'h5, s[5:3] == 3'h1,
            s[5:3] != 3'h1 && s[5:3] != 3'h5, 1'b1};
    endfunction
    task automatic check_all(input logic [11:0] s);
        logic [4:0] fa [3];
        rd(`PSL_OFS_STRAP_RAW, rd_v, rs); `CHK(rd_v, {20'h0, s})
        rd(`PSL_OFS_CTRL_SEED, rd_v, rs); `CHK(rd_v, exp_ctrl(s))
        rd(`PSL_OFS_ADV_SEED, rd_v, rs); `CHK(rd_v, s[7] ? 32'h0000_01E1 : 32'h0000_0061)
        rd(`PSL_OFS_STATUS, rd_v, rs); `CHK(rd_v, exp_stat(s))
        `CHK(maddr, {2'b00, s[2:0]})
        fa = '{{2'b00, s[2:0]}, 5'h00, 5'($urandom)};
        foreach (fa[i])
        begin
            @(posedge aclk) frame <= fa[i];
            @(posedge aclk);
            @(negedge aclk);
            `CHK(match, fa[i] == {2'b00, s[2:0]} || (fa[i] == 0 && !s[10]))
        end
    endtask
    task automatic run_case(input logic [11:0] v, input logic [11:0] m);
        logic [11:0] s;
        s = (m & v) | (~m & 12'hB81);
        last_s = s;
        @(posedge aclk);
        bval <= v; bmask <= m; aresetn <= 0; fdrv <= 12'hFFF;
        repeat (6) @(posedge aclk);
        @(negedge aclk);
        `CHK({valid, pull_en, oe_n}, 14'h1FFF)
        @(posedge aclk) aresetn <= 1;
        repeat (2) @(posedge aclk);
        check_all(s);
        @(posedge aclk);
        bval <= ~v; bmask <= 12'($urandom); fout <= 12'($urandom); fdrv <= 12'($urandom);
        repeat (3) @(posedge aclk);
        @(negedge aclk);
        `CHK(oe_n, ~fdrv)
        `CHK(pout, fout)
        check_all(s);
        $display("case v=%0h m=%0h done", v, m);
    endtask
    initial
    begin
        void'($urandom(45));
        run_case(12'h000, 12'h000);
        run_case(12'h448, 12'hFFF);
        run_case(12'h82F, 12'hFFF);
        repeat (6) run_case(12'($urandom), 12'($urandom));
        wr(`PSL_OFS_PIN_CTRL, 32'h1, rs); `CHK(rs, 2'h0)
        fdrv <= 12'hFFF;
        repeat (2) @(posedge aclk);
        @(negedge aclk);
        `CHK(oe_n, 12'hFFF)
        rd(`PSL_OFS_PIN_CTRL, rd_v, rs); `CHK(rd_v, 32'h0000_0001)
        wr(`PSL_OFS_PIN_CTRL, 32'h0, rs); `CHK(rs, 2'h0)
        @(negedge aclk);
        `CHK(oe_n, 12'h000)
        wr(`PSL_OFS_CTRL_SEED, 32'hFFFF_FFFF, rs); `CHK(rs, 2'h0)
        rd(`PSL_OFS_CTRL_SEED, rd_v, rs); `CHK(rd_v, exp_ctrl(last_s))
        wr(8'h14, 32'h1, rs); `CHK(rs, 2'h2)
        rd(8'h14, rd_v, rs); `CHK(rs, 2'h2)
        $display("bus case done");
        print_verdict();
    end
endmodule // tb

//--- verilog/psl_regs.vh
// register offsets, field positions and reset values of the strap latch
//
// Function
// - The three low management address bits are caught from their strap pins at reset release, giving any address 0 to 7.
// - With nothing strapped, the pin pulls make the caught management address 00001.
// - Management address bits 4 and 3 cannot be strapped and always read zero.
// - Address 00000 is this device's own unique address only when the zero-unique strap was caught high.
// - A low zero-unique strap makes address zero a broadcast address, a high one makes it unique.
// - The three mode strap bits are caught at reset release; 001 is RMII, 101 is RMII back-to-back, the rest are reserved.
// - The isolate strap seeds control bit 10, high enabling isolate and low (default) disabling it.
// - The speed strap seeds control bit 13 (high 100 Mbps, default) and the speed capability in the advertisement.
// - The duplex strap seeds control bit 8, high (default) half duplex and low full duplex.
// - The auto-negotiation strap seeds control bit 12, high (default) enabling and low disabling it.
// - The test-tree strap is caught; high (default) leaves NAND-tree mode off, low turns it on.
// - Each strap pin is a pulled input during reset and becomes an output for its normal use afterwards; here it stays an input while hold_input_r is set.
`ifndef PSL_REGS_VH
`define PSL_REGS_VH

`define PSL_OFS_STRAP_RAW     8'h00
`define PSL_OFS_CTRL_SEED     8'h04
`define PSL_OFS_ADV_SEED      8'h08
`define PSL_OFS_STATUS        8'h0C
`define PSL_OFS_PIN_CTRL      8'h10

`define PSL_NPIN              12
`define PSL_PIN_ADDR0         0
`define PSL_PIN_ADDR2         2
`define PSL_PIN_MODE0         3
`define PSL_PIN_MODE2         5
`define PSL_PIN_ISOLATE       6
`define PSL_PIN_SPEED         7
`define PSL_PIN_DUPLEX        8
`define PSL_PIN_AUTONEG       9
`define PSL_PIN_ZERO_UNIQUE   10
`define PSL_PIN_TEST_TREE_N   11

`define PSL_PULL_UP_MASK      12'hB81
`define PSL_STRAP_RST         12'hB81

`define PSL_CTRL_DUPLEX_BIT   8
`define PSL_CTRL_ISOLATE_BIT  10
`define PSL_CTRL_AUTONEG_BIT  12
`define PSL_CTRL_SPEED_BIT    13
`define PSL_ADV_SELECTOR      16'h0001
`define PSL_ADV_10HD_BIT      5
`define PSL_ADV_10FD_BIT      6
`define PSL_ADV_100HD_BIT     7
`define PSL_ADV_100FD_BIT     8

`define PSL_MODE_RMII         3'h1
`define PSL_MODE_B2B          3'h5

`define PSL_STAT_VALID_BIT    0
`define PSL_STAT_RSVD_BIT     1
`define PSL_STAT_RMII_BIT     2
`define PSL_STAT_B2B_BIT      3
`define PSL_STAT_BCAST_BIT    4
`define PSL_STAT_NAND_BIT     5
`define PSL_STAT_ADDR_LSB     8

`define PSL_PINCTRL_HOLD_BIT  0
`define PSL_PINCTRL_RST       32'h0000_0000

`define PSL_RESP_OKAY         2'h0
`define PSL_RESP_SLVERR       2'h2

`endif

//--- verilog/psl_strap_latch.v
// strap capture, strap pin turnaround and axi4-lite status view
//
// Local design decisions: the address map and register access over AXI4-Lite.
`timescale 1ns/10ps
`include "psl_regs.vh"
module psl_strap_latch (
    aclk,
    aresetn,
    s_axi_awaddr,
    s_axi_awprot,
    s_axi_awvalid,
    s_axi_awready,
    s_axi_wdata,
    s_axi_wstrb,
    s_axi_wvalid,
    s_axi_wready,
    s_axi_bresp,
    s_axi_bvalid,
    s_axi_bready,
    s_axi_araddr,
    s_axi_arprot,
    s_axi_arvalid,
    s_axi_arready,
    s_axi_rdata,
    s_axi_rresp,
    s_axi_rvalid,
    s_axi_rready,
    strap_pin_in,
    strap_pin_out,
    strap_pin_oe_n,
    strap_pull_en,
    strap_pull_up,
    func_pin_out,
    func_pin_drive,
    mgmt_frame_addr,
    mgmt_addr,
    addr_match,
    addr_is_bcast,
    mode_code,
    mode_rmii,
    mode_b2b,
    mode_reserved,
    ctrl_seed,
    adv_seed,
    nand_tree_en,
    straps_valid
);
    input  wire        aclk;
    input  wire        aresetn;
    input  wire [7:0]  s_axi_awaddr;
    input  wire [2:0]  s_axi_awprot;
    input  wire        s_axi_awvalid;
    output wire        s_axi_awready;
    input  wire [31:0] s_axi_wdata;
    input  wire [3:0]  s_axi_wstrb;
    input  wire        s_axi_wvalid;
    output wire        s_axi_wready;
    output reg  [1:0]  s_axi_bresp;
    output reg         s_axi_bvalid;
    input  wire        s_axi_bready;
    input  wire [7:0]  s_axi_araddr;
    input  wire [2:0]  s_axi_arprot;
    input  wire        s_axi_arvalid;
    output wire        s_axi_arready;
    output reg  [31:0] s_axi_rdata;
    output reg  [1:0]  s_axi_rresp;
    output reg         s_axi_rvalid;
    input  wire        s_axi_rready;
    input  wire [11:0] strap_pin_in;
    output reg  [11:0] strap_pin_out;
    output wire [11:0] strap_pin_oe_n;
    output wire        strap_pull_en;
    output wire [11:0] strap_pull_up;
    input  wire [11:0] func_pin_out;
    input  wire [11:0] func_pin_drive;
    input  wire [4:0]  mgmt_frame_addr;
    output wire [4:0]  mgmt_addr;
    output reg         addr_match;
    output wire        addr_is_bcast;
    output wire [2:0]  mode_code;
    output wire        mode_rmii;
    output wire        mode_b2b;
    output wire        mode_reserved;
    output wire [15:0] ctrl_seed;
    output wire [15:0] adv_seed;
    output wire        nand_tree_en;
    output wire        straps_valid;

    wire [11:0] pin_sync;
    reg         in_reset_r;
    reg  [11:0] strap_r;
    reg         valid_r;
    reg         hold_input_r;
    wire        capture;
    wire        release_pins;
    wire        speed100;
    reg         mode_rmii_r;
    reg         mode_b2b_r;
    reg         mode_rsvd_r;
    reg         bcast_r;
    reg         nand_r;
    wire [2:0]  mode_pins;
    localparam [11:0] STRAP_RST = `PSL_STRAP_RST;
    localparam [2:0]  RST_MODE  = STRAP_RST[`PSL_PIN_MODE2:`PSL_PIN_MODE0];

    // board pins come from outside the clock domain
    psl_sync2 #(
        .WIDTH (`PSL_NPIN)
    ) u_pin_sync (
        .aclk (aclk),
        .d    (strap_pin_in),
        .q    (pin_sync)
    );

    // ------------------------------------------------------------------
    // strap capture
    // ------------------------------------------------------------------
    always @(posedge aclk)
    begin
        if (!aresetn)
            in_reset_r <= 1'b1;
        else
            in_reset_r <= 1'b0;
    end

    // first edge with reset high after a reset period
    assign capture = aresetn & in_reset_r;

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            strap_r <= `PSL_STRAP_RST;
            valid_r <= 1'b0;
        end
        else if (capture)
        begin
            strap_r <= pin_sync;
            valid_r <= 1'b1;
        end
    end

    // decodes are registered at capture so the flags leave on flops, not gates
    assign mode_pins = pin_sync[`PSL_PIN_MODE2:`PSL_PIN_MODE0];

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            mode_rmii_r <= (RST_MODE == `PSL_MODE_RMII);
            mode_b2b_r  <= (RST_MODE == `PSL_MODE_B2B);
            mode_rsvd_r <= (RST_MODE != `PSL_MODE_RMII) && (RST_MODE != `PSL_MODE_B2B);
            bcast_r     <= ~STRAP_RST[`PSL_PIN_ZERO_UNIQUE];
            nand_r      <= ~STRAP_RST[`PSL_PIN_TEST_TREE_N];
        end
        else if (capture)
        begin
            mode_rmii_r <= (mode_pins == `PSL_MODE_RMII);
            mode_b2b_r  <= (mode_pins == `PSL_MODE_B2B);
            mode_rsvd_r <= (mode_pins != `PSL_MODE_RMII) && (mode_pins != `PSL_MODE_B2B);
            bcast_r     <= ~pin_sync[`PSL_PIN_ZERO_UNIQUE];
            nand_r      <= ~pin_sync[`PSL_PIN_TEST_TREE_N];
        end
    end

    assign straps_valid = valid_r;

    // ------------------------------------------------------------------
    // pin turnaround: pulled inputs until capture, then normal outputs unless hold_input_r is set
    // ------------------------------------------------------------------
    assign release_pins   = valid_r & ~hold_input_r;
    assign strap_pull_en  = ~valid_r;
    assign strap_pull_up  = `PSL_PULL_UP_MASK;
    assign strap_pin_oe_n = ~({`PSL_NPIN{release_pins}} & func_pin_drive);

    always @(posedge aclk)
    begin
        if (!aresetn)
            strap_pin_out <= 12'h000;
        else
            strap_pin_out <= func_pin_out;
    end

    // ------------------------------------------------------------------
    // decoded strap values
    // ------------------------------------------------------------------
    // upper address bits are not strappable
    assign mgmt_addr = {2'b00, strap_r[`PSL_PIN_ADDR2:`PSL_PIN_ADDR0]};

    assign addr_is_bcast = bcast_r;

    // address zero hits either as broadcast or, with all three address straps low, as our own
    always @(posedge aclk)
    begin
        if (!aresetn)
            addr_match <= 1'b0;
        else if (mgmt_frame_addr == 5'h00)
            addr_match <= valid_r & (addr_is_bcast | (mgmt_addr == 5'h00));
        else
            addr_match <= valid_r & (mgmt_frame_addr == mgmt_addr);
    end

    assign mode_code     = strap_r[`PSL_PIN_MODE2:`PSL_PIN_MODE0];
    assign mode_rmii     = mode_rmii_r;
    assign mode_b2b      = mode_b2b_r;
    assign mode_reserved = mode_rsvd_r;

    assign nand_tree_en = nand_r;

    assign speed100 = strap_r[`PSL_PIN_SPEED];

    // control register seed: only the strapped bits are set here
    assign ctrl_seed = (16'h0000
                        | ({15'h0000, speed100} << `PSL_CTRL_SPEED_BIT)
                        | ({15'h0000, strap_r[`PSL_PIN_AUTONEG]} << `PSL_CTRL_AUTONEG_BIT)
                        | ({15'h0000, strap_r[`PSL_PIN_ISOLATE]} << `PSL_CTRL_ISOLATE_BIT)
                        | ({15'h0000, strap_r[`PSL_PIN_DUPLEX]} << `PSL_CTRL_DUPLEX_BIT));

    // 10 Mbps abilities always offered, 100 Mbps only with the speed strap high
    assign adv_seed = (`PSL_ADV_SELECTOR
                       | (16'h0001 << `PSL_ADV_10HD_BIT)
                       | (16'h0001 << `PSL_ADV_10FD_BIT)
                       | ({15'h0000, speed100} << `PSL_ADV_100HD_BIT)
                       | ({15'h0000, speed100} << `PSL_ADV_100FD_BIT));

    // ------------------------------------------------------------------
    // axi4-lite write channel
    // ------------------------------------------------------------------
    reg        aw_held_r;
    reg [7:0]  aw_addr_r;
    reg        w_held_r;
    reg [31:0] w_data_r;
    reg [3:0]  w_strb_r;
    wire       do_write;
    wire       wr_to_pin_ctrl;
    wire       wr_to_ro;

    // word offsets cut to the decoded address bits [7:2]
    localparam [7:0] OFS_STRAP_RAW = `PSL_OFS_STRAP_RAW;
    localparam [7:0] OFS_CTRL_SEED = `PSL_OFS_CTRL_SEED;
    localparam [7:0] OFS_ADV_SEED  = `PSL_OFS_ADV_SEED;
    localparam [7:0] OFS_STATUS    = `PSL_OFS_STATUS;
    localparam [7:0] OFS_PIN_CTRL  = `PSL_OFS_PIN_CTRL;
    localparam [5:0] IDX_STRAP_RAW = OFS_STRAP_RAW[7:2];
    localparam [5:0] IDX_CTRL_SEED = OFS_CTRL_SEED[7:2];
    localparam [5:0] IDX_ADV_SEED  = OFS_ADV_SEED[7:2];
    localparam [5:0] IDX_STATUS    = OFS_STATUS[7:2];
    localparam [5:0] IDX_PIN_CTRL  = OFS_PIN_CTRL[7:2];

    // each of address and data is taken once and parked until both are here
    assign s_axi_awready = ~aw_held_r & ~s_axi_bvalid;
    assign s_axi_wready  = ~w_held_r & ~s_axi_bvalid;
    assign do_write      = aw_held_r & w_held_r & ~s_axi_bvalid;

    // read-only words ignore the data but still answer okay
    assign wr_to_pin_ctrl = (aw_addr_r[7:2] == IDX_PIN_CTRL);
    assign wr_to_ro       = (aw_addr_r[7:2] == IDX_STRAP_RAW) ||
                            (aw_addr_r[7:2] == IDX_CTRL_SEED) ||
                            (aw_addr_r[7:2] == IDX_ADV_SEED)  ||
                            (aw_addr_r[7:2] == IDX_STATUS);

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held_r <= 1'b0;
            aw_addr_r <= 8'h00;
            w_held_r  <= 1'b0;
            w_data_r  <= 32'h0000_0000;
            w_strb_r  <= 4'h0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_held_r <= 1'b1;
                aw_addr_r <= s_axi_awaddr;
            end
            else if (do_write)
                aw_held_r <= 1'b0;
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_held_r <= 1'b1;
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
            end
            else if (do_write)
                w_held_r <= 1'b0;
        end
    end

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            hold_input_r <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `PSL_RESP_OKAY;
        end
        else if (do_write)
        begin
            s_axi_bvalid <= 1'b1;
            if (wr_to_pin_ctrl)
            begin
                s_axi_bresp <= `PSL_RESP_OKAY;
                if (w_strb_r[0])
                    hold_input_r <= w_data_r[`PSL_PINCTRL_HOLD_BIT];
            end
            else if (wr_to_ro)
                s_axi_bresp <= `PSL_RESP_OKAY; // read-only, write ignored
            else
                s_axi_bresp <= `PSL_RESP_SLVERR;
        end
        else if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
    end

    // ------------------------------------------------------------------
    // axi4-lite read channel
    // ------------------------------------------------------------------
    reg [31:0] rd_data;
    reg        rd_err;
    wire [31:0] status_word;

    assign s_axi_arready = ~s_axi_rvalid;

    assign status_word = {16'h0000, 3'b000, mgmt_addr, 2'b00,
                          nand_tree_en, addr_is_bcast, mode_b2b, mode_rmii,
                          mode_reserved, valid_r};

    always @*
    begin
        rd_data = 32'h0000_0000;
        rd_err  = 1'b0;
        case (s_axi_araddr[7:2])
            IDX_STRAP_RAW: rd_data = {20'h0_0000, strap_r};
            IDX_CTRL_SEED: rd_data = {16'h0000, ctrl_seed};
            IDX_ADV_SEED:  rd_data = {16'h0000, adv_seed};
            IDX_STATUS:    rd_data = status_word;
            IDX_PIN_CTRL:  rd_data = {31'h0000_0000, hold_input_r};
            default:                 rd_err  = 1'b1;
        endcase
    end

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= `PSL_RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_data;
            s_axi_rresp  <= rd_err ? `PSL_RESP_SLVERR : `PSL_RESP_OKAY;
        end
        else if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end

endmodule // psl_strap_latch

//--- verilog/psl_sync2.v
// two-flop synchroniser for a group of pin levels
`timescale 1ns/10ps
module psl_sync2 #(
    parameter WIDTH = 1
) (
    aclk,
    d,
    q
);
    input  wire             aclk;
    input  wire [WIDTH-1:0] d;
    output reg  [WIDTH-1:0] q;

    reg [WIDTH-1:0] meta_r;

    // no reset: the straps must be tracked while reset is held
    always @(posedge aclk)
    begin
        meta_r <= d;
        q      <= meta_r;
    end
endmodule // psl_sync2
